//--- dv/ssr_slave_model.sv
// far-side synchronous slave: shifts a stream of characters out, lsb first
`timescale 1ns/1ns
module ssr_slave_model (
    input wire logic ck_i,
    input wire logic pol_i,
    input wire logic nine_i,
    input wire logic slow_i,
    input wire logic load_i,
    input wire logic [8:0] base_i,
    output logic dt_o
);
    logic [8:0] word;
    int idx;
    initial begin
        dt_o = 1'b0;
        idx = 0;
        word = '0;
    end
    always @(posedge load_i) begin
        word = base_i;
        idx = 0;
    end
    // each new character counts up, so a dropped one shows as a gap
    always @(ck_i) begin
        if (ck_i != pol_i) begin
            // late change stays clear of the sampling edges
            #(slow_i ? 23 : 2);
            dt_o = word[idx];
            idx = idx + 1;
        end else if (idx >= (nine_i ? 9 : 8)) begin
            idx = 0;
            word = word + 9'h001;
            #30;
            dt_o = ~dt_o;
        end
    end
endmodule : ssr_slave_model

//--- dv/ssr_sva.sv
// concurrent checks on the receiver ports
`timescale 1ns/1ns
module ssr_sva (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic ck_i,
    input wire logic ck_o,
    input wire logic ck_oe_o,
    input wire logic dt_i,
    input wire logic rx_irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    logic wr;
    logic en_q, sm_q, pol_q, wide_q, ie_q;
    logic [7:0] lo_q;
    logic [16:0] act_q;
    assign wr = psel_i && penable_i && pready_o && pwrite_i;
    //////////////////////////////////////////////////////////////////////
    // shadow of the software view, taken at the edge where a write lands
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            {en_q, sm_q, pol_q, wide_q, ie_q, lo_q} <= '0;
        end else if (wr) begin
            if (paddr_i == ssr_pkg::ADDR_RX_STATUS) en_q <= pwdata_i[7];
            if (paddr_i == ssr_pkg::ADDR_TX_STATUS) sm_q <= pwdata_i[7] && pwdata_i[4];
            if (paddr_i == ssr_pkg::ADDR_BAUD_CONTROL) {pol_q, wide_q} <= pwdata_i[4:3];
            if (paddr_i == ssr_pkg::ADDR_DIV_LOW) lo_q <= pwdata_i[7:0];
            if (paddr_i == ssr_pkg::ADDR_INT_CONTROL) ie_q <= pwdata_i[0];
        end
    end
    // run length of the active clock level; an abort only shortens it
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || ck_o == pol_q) begin
            act_q <= '0;
        end else begin
            act_q <= act_q + 17'h00001;
        end
    end
    //////////////////////////////////////////////////////////////////////
    chk_ready_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
        else $error("ready not in second access cycle");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("refused access without ready or with data");
    chk_upper_zero: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0)
        else $error("unused read bits not zero");
    chk_oe_follows: assert property ($stable(en_q && sm_q) |-> ck_oe_o == (en_q && sm_q))
        else $error("clock pin drive mismatch");
    chk_idle_slave: assert property (!sm_q && !$past(sm_q) && $stable(pol_q) |-> ck_o == pol_q)
        else $error("clock pin not at idle level");
    chk_half_limit: assert property (!wide_q |-> act_q <= {9'h000, lo_q} + 17'h00001)
        else $error("active clock phase too long");
    chk_irq_enable: assert property (rx_irq_o |-> ie_q || $past(ie_q))
        else $error("interrupt while disabled");
    chk_irq_disable: assert property (wr && paddr_i == ssr_pkg::ADDR_RX_STATUS && !pwdata_i[7]
        |-> ##3 !rx_irq_o)
        else $error("interrupt kept after port disable");
endmodule : ssr_sva

//--- dv/tb_sync_serial_receiver.sv
// testbench of the synchronous serial receiver
`timescale 1ns/1ns
module tb_sync_serial_receiver;
    logic clk, rst, psel, pen, pwr, pready, perr, err, ck_o, ck_oe, dt, irq, tb_ck, ck_pin;
    logic pol, nine, slow, load;
    logic [7:0] paddr;
    logic [8:0] base;
    logic [31:0] pwdata, prdata, rd;
    int miscompares, check_count, lead, snap;
    assign ck_pin = ck_oe ? ck_o : tb_ck;
    ssr_receiver i_dut (.sys_clk_i(clk), .srst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(perr), .ck_i(ck_pin), .ck_o(ck_o), .ck_oe_o(ck_oe), .dt_i(dt), .rx_irq_o(irq));
    ssr_slave_model i_far (.ck_i(ck_pin), .pol_i(pol), .nine_i(nine), .slow_i(slow),
        .load_i(load), .base_i(base), .dt_o(dt));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(ck_pin) if (ck_pin !== pol) lead = lead + 1;
    //////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        // ready, data and error are taken at the edge where ready is sampled high
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            $display("ERROR %0t: no ready", $time);
        end
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : xfer
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task start(input logic [8:0] b, input logic [7:0] c);
        base <= b;
        load <= 1'b1;
        lead = 0;
        @(posedge clk);
        load <= 1'b0;
        xfer(1'b1, ssr_pkg::ADDR_RX_STATUS, {24'h0, c});
    endtask : start
    task wait_on(input int bit_pos, input logic lvl);
        int n;
        n = 0;
        do begin
            xfer(1'b0, ssr_pkg::ADDR_RX_STATUS, 32'h0);
            n++;
        end while (rd[bit_pos] !== lvl && n < 300);
        if (rd[bit_pos] !== lvl) begin
            miscompares++;
            $display("ERROR %0t: status bit never reached", $time);
        end
    endtask : wait_on
    task summarize;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        $display("ERROR %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        {psel, pen, pwr, paddr, pwdata, tb_ck, pol, nine, slow, load, base, err} = '0;
        {miscompares, check_count, lead} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdc(ssr_pkg::ADDR_RX_STATUS, 32'h0);
        rdc(8'h1C, 32'h0);
        chk({31'h0, err}, 32'h1);
        xfer(1'b1, ssr_pkg::ADDR_DIV_LOW, 32'hFFFF_FF05);
        rdc(ssr_pkg::ADDR_DIV_LOW, 32'h5);
        xfer(1'b1, ssr_pkg::ADDR_TX_STATUS, 32'h90);
        xfer(1'b1, ssr_pkg::ADDR_INT_CONTROL, 32'h1);
        xfer(1'b1, ssr_pkg::ADDR_RX_STATUS, 32'h80);
        // pin enable is registered one cycle behind the write
        repeat (2) @(posedge clk);
        chk({31'h0, ck_oe}, 32'h1);
        start(9'h0A5, 8'hA0);
        wait_on(5, 1'b0);
        chk(32'(lead), 32'h8);
        rdc(ssr_pkg::ADDR_INT_CONTROL, 32'h3);
        chk({31'h0, irq}, 32'h1);
        rdc(ssr_pkg::ADDR_RX_DATA, 32'hA5);
        rdc(ssr_pkg::ADDR_INT_CONTROL, 32'h1);
        chk({31'h0, irq}, 32'h0);
        slow <= 1'b1;
        start(9'h03C, 8'h90);
        wait_on(1, 1'b1);
        repeat (200) @(posedge clk);
        chk(32'(lead), 32'h18);
        rdc(ssr_pkg::ADDR_RX_DATA, 32'h3C);
        rdc(ssr_pkg::ADDR_RX_STATUS, 32'h92);
        rdc(ssr_pkg::ADDR_RX_DATA, 32'h3D);
        xfer(1'b1, ssr_pkg::ADDR_RX_STATUS, 32'h80);
        rdc(ssr_pkg::ADDR_RX_STATUS, 32'h80);
        slow <= 1'b0;
        start(9'h011, 8'hB0);
        wait_on(5, 1'b0);
        rdc(ssr_pkg::ADDR_RX_STATUS, 32'h90);
        while (lead < 11) @(posedge clk);
        xfer(1'b1, ssr_pkg::ADDR_RX_STATUS, 32'h80);
        snap = lead;
        repeat (50) @(posedge clk);
        chk(32'(lead), 32'(snap));
        chk({31'h0, ck_o}, 32'h0);
        rdc(ssr_pkg::ADDR_RX_DATA, 32'h11);
        rdc(ssr_pkg::ADDR_INT_CONTROL, 32'h1);
        for (int k = 0; k < 3; k++) begin
            start(9'h020 + 9'(k), 8'hA0);
            wait_on(5, 1'b0);
        end
        rdc(ssr_pkg::ADDR_RX_STATUS, 32'h82);
        rdc(ssr_pkg::ADDR_RX_DATA, 32'h20);
        rdc(ssr_pkg::ADDR_RX_STATUS, 32'h80);
        xfer(1'b1, ssr_pkg::ADDR_RX_STATUS, 32'h0);
        rdc(ssr_pkg::ADDR_INT_CONTROL, 32'h1);
        xfer(1'b1, ssr_pkg::ADDR_RX_STATUS, 32'h80);
        pol <= 1'b1;
        xfer(1'b1, ssr_pkg::ADDR_BAUD_CONTROL, 32'h10);
        repeat (3) @(posedge clk);
        chk({31'h0, ck_o}, 32'h1);
        nine <= 1'b1;
        start(9'h15A, 8'hE0);
        wait_on(5, 1'b0);
        chk(32'(lead), 32'h9);
        rdc(ssr_pkg::ADDR_RX_STATUS, 32'hC1);
        rdc(ssr_pkg::ADDR_RX_DATA, 32'h5A);
        rdc(ssr_pkg::ADDR_RX_STATUS, 32'hC0);
        nine <= 1'b0;
        xfer(1'b1, ssr_pkg::ADDR_BAUD_CONTROL, 32'h0);
        pol <= 1'b0;
        xfer(1'b1, ssr_pkg::ADDR_TX_STATUS, 32'h10);
        repeat (2) @(posedge clk);
        chk({31'h0, ck_oe}, 32'h0);
        start(9'h0C3, 8'hA0);
        #3;
        // link clock runs only within the frame, eight cycles for eight bits
        repeat (8) begin
            tb_ck <= 1'b1;
            #62;
            tb_ck <= 1'b0;
            #63;
        end
        wait_on(5, 1'b0);
        rdc(ssr_pkg::ADDR_RX_DATA, 32'hC3);
        summarize();
    end
endmodule : tb_sync_serial_receiver
bind ssr_receiver ssr_sva i_sva (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ck_i(ck_i), .ck_o(ck_o),
    .ck_oe_o(ck_oe_o), .dt_i(dt_i), .rx_irq_o(rx_irq_o));

//--- src/ssr_pkg.sv
// constants, register map and carrier types of the synchronous serial receiver
//////////////////////////////////////////////////////////////////////////////
package ssr_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_RX_STATUS = 8'h00;
    localparam logic [7:0] ADDR_RX_DATA = 8'h04;
    localparam logic [7:0] ADDR_TX_STATUS = 8'h08;
    localparam logic [7:0] ADDR_BAUD_CONTROL = 8'h0C;
    localparam logic [7:0] ADDR_DIV_LOW = 8'h10;
    localparam logic [7:0] ADDR_DIV_HIGH = 8'h14;
    localparam logic [7:0] ADDR_INT_CONTROL = 8'h18;

    // receive status fields
    localparam int RXS_PORT_EN = 7;
    localparam int RXS_NINE_BIT = 6;
    localparam int RXS_SINGLE = 5;
    localparam int RXS_CONT = 4;
    localparam int RXS_OVERRUN = 1;
    localparam int RXS_NINTH = 0;
    // transmit status fields
    localparam int TXS_MASTER = 7;
    localparam int TXS_SYNC = 4;
    localparam int TXS_HIGH_SPEED = 2;
    // baud control fields
    localparam int BDC_IDLE = 6;
    localparam int BDC_POLARITY = 4;
    localparam int BDC_WIDE = 3;
    // interrupt control fields
    localparam int INT_ENABLE = 0;
    localparam int INT_FLAG = 1;

    localparam logic [3:0] CHAR_BITS_8 = 4'h8;
    localparam logic [3:0] CHAR_BITS_9 = 4'h9;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic port_en;
        logic nine_bit;
        logic master;
        logic sync;
        logic polarity;
        logic wide;
        logic high_speed;
    } ssr_cfg_s;

    localparam ssr_cfg_s CFG_RESET = '{default: 1'b0};

    typedef struct packed {
        logic ninth;
        logic [7:0] low;
    } ssr_char_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_ACTIVE = 2'b11,
        ST_DONE = 2'b10
    } ssr_state_e;
endpackage : ssr_pkg

//--- src/ssr_rate_gen.sv
// shift clock rate generator: one tick per half shift clock period
`timescale 1ns/1ns
module ssr_rate_gen (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic run_i,
    input wire logic wide_i,
    input wire logic [15:0] divisor_i,
    output logic tick_o
);
    logic [15:0] cnt_q;
    logic [15:0] div_eff;

    // narrow mode only honours the low divisor byte
    assign div_eff = wide_i ? divisor_i : {8'h00, divisor_i[7:0]};

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !run_i) begin
            cnt_q <= ssr_pkg::DIV_RESET;
            tick_o <= 1'b0;
        end else if (cnt_q >= div_eff) begin
            cnt_q <= ssr_pkg::DIV_RESET;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule : ssr_rate_gen

//--- src/ssr_receiver.sv
// synchronous serial receiver with apb registers, clock pin control and receive fifo
`timescale 1ns/1ns
module ssr_receiver #(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ck_i,
    output logic ck_o,
    output logic ck_oe_o,
    input wire logic dt_i,
    output logic rx_irq_o
);
    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam logic [CW-1:0] FIFO_FULL = CW'(FIFO_DEPTH);

    //////////////////////////////////////////////////////////////////////////
    // declarations
    ssr_pkg::ssr_cfg_s cfg_q;
    logic single_q;
    logic cont_q;
    logic rx_ie_q;
    logic [15:0] div_q;
    logic overrun_q;
    logic ovr_cont_q;
    ssr_pkg::ssr_state_e state_q;
    logic [3:0] bit_cnt_q;
    logic [8:0] rsr_q;
    ssr_pkg::ssr_char_s fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic ck_meta_q;
    logic ck_sync_q;
    logic ck_prev_q;
    logic dt_meta_q;
    logic dt_sync_q;
    logic tick;
    logic access;
    logic wr_fire;
    logic rd_fire;
    logic rx_run;
    logic step_lead;
    logic step_trail;
    logic slave_lead;
    logic slave_trail;
    logic char_done;
    logic fifo_full;
    logic fifo_empty;
    logic push;
    logic pop;
    logic [3:0] last_bit;
    logic [31:0] rd_val;
    ssr_pkg::ssr_char_s head;

    //////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            ssr_pkg::ADDR_RX_STATUS, ssr_pkg::ADDR_RX_DATA, ssr_pkg::ADDR_TX_STATUS,
            ssr_pkg::ADDR_BAUD_CONTROL, ssr_pkg::ADDR_DIV_LOW, ssr_pkg::ADDR_DIV_HIGH,
            ssr_pkg::ADDR_INT_CONTROL: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    function automatic logic is_write_to(input logic [7:0] a);
        is_write_to = wr_fire && (paddr_i == a);
    endfunction : is_write_to

    //////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, write and pop at the edge pready is sampled
    assign access = psel_i && penable_i;
    assign wr_fire = access && pready_o && pwrite_i;
    assign rd_fire = access && pready_o && !pwrite_i;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= ssr_pkg::WORD_ZERO;
        end else begin
            pready_o <= access && !pready_o;
            pslverr_o <= access && !pready_o && !addr_mapped(paddr_i);
            if (access && !pready_o) begin
                prdata_o <= pwrite_i ? ssr_pkg::WORD_ZERO : rd_val;
            end
        end
    end

    assign head = fifo_mem[rd_ptr_q];

    // unimplemented positions stay zero from the initial clear
    always_comb begin
        rd_val = ssr_pkg::WORD_ZERO;
        case (paddr_i)
            ssr_pkg::ADDR_RX_STATUS: begin
                rd_val[ssr_pkg::RXS_PORT_EN] = cfg_q.port_en;
                rd_val[ssr_pkg::RXS_NINE_BIT] = cfg_q.nine_bit;
                rd_val[ssr_pkg::RXS_SINGLE] = single_q;
                rd_val[ssr_pkg::RXS_CONT] = cont_q;
                rd_val[ssr_pkg::RXS_OVERRUN] = overrun_q;
                rd_val[ssr_pkg::RXS_NINTH] = head.ninth && !fifo_empty;
            end
            ssr_pkg::ADDR_RX_DATA: begin
                rd_val[7:0] = fifo_empty ? ssr_pkg::BYTE_RESET : head.low;
            end
            ssr_pkg::ADDR_TX_STATUS: begin
                rd_val[ssr_pkg::TXS_MASTER] = cfg_q.master;
                rd_val[ssr_pkg::TXS_SYNC] = cfg_q.sync;
                rd_val[ssr_pkg::TXS_HIGH_SPEED] = cfg_q.high_speed;
            end
            ssr_pkg::ADDR_BAUD_CONTROL: begin
                rd_val[ssr_pkg::BDC_IDLE] = (state_q == ssr_pkg::ST_IDLE);
                rd_val[ssr_pkg::BDC_POLARITY] = cfg_q.polarity;
                rd_val[ssr_pkg::BDC_WIDE] = cfg_q.wide;
            end
            ssr_pkg::ADDR_DIV_LOW: begin
                rd_val[7:0] = div_q[7:0];
            end
            ssr_pkg::ADDR_DIV_HIGH: begin
                rd_val[7:0] = div_q[15:8];
            end
            ssr_pkg::ADDR_INT_CONTROL: begin
                rd_val[ssr_pkg::INT_ENABLE] = rx_ie_q;
                rd_val[ssr_pkg::INT_FLAG] = !fifo_empty;
            end
            default: begin
                rd_val = ssr_pkg::WORD_ZERO;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cfg_q <= ssr_pkg::CFG_RESET;
            div_q <= ssr_pkg::DIV_RESET;
            rx_ie_q <= 1'b0;
            cont_q <= 1'b0;
        end else begin
            if (is_write_to(ssr_pkg::ADDR_RX_STATUS)) begin
                cfg_q.port_en <= pwdata_i[ssr_pkg::RXS_PORT_EN];
                cfg_q.nine_bit <= pwdata_i[ssr_pkg::RXS_NINE_BIT];
                cont_q <= pwdata_i[ssr_pkg::RXS_CONT];
            end
            if (is_write_to(ssr_pkg::ADDR_TX_STATUS)) begin
                cfg_q.master <= pwdata_i[ssr_pkg::TXS_MASTER];
                cfg_q.sync <= pwdata_i[ssr_pkg::TXS_SYNC];
                cfg_q.high_speed <= pwdata_i[ssr_pkg::TXS_HIGH_SPEED];
            end
            if (is_write_to(ssr_pkg::ADDR_BAUD_CONTROL)) begin
                cfg_q.polarity <= pwdata_i[ssr_pkg::BDC_POLARITY];
                cfg_q.wide <= pwdata_i[ssr_pkg::BDC_WIDE];
            end
            if (is_write_to(ssr_pkg::ADDR_DIV_LOW)) begin
                div_q[7:0] <= pwdata_i[7:0];
            end
            if (is_write_to(ssr_pkg::ADDR_DIV_HIGH)) begin
                div_q[15:8] <= pwdata_i[7:0];
            end
            if (is_write_to(ssr_pkg::ADDR_INT_CONTROL)) begin
                rx_ie_q <= pwdata_i[ssr_pkg::INT_ENABLE];
            end
        end
    end

    // a software write in the completion cycle wins, so a fresh request is kept
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            single_q <= 1'b0;
        end else if (is_write_to(ssr_pkg::ADDR_RX_STATUS)) begin
            single_q <= pwdata_i[ssr_pkg::RXS_SINGLE];
        end else if (char_done) begin
            single_q <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers and slave clock edge detection
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ck_meta_q <= 1'b0;
            ck_sync_q <= 1'b0;
            ck_prev_q <= 1'b0;
            dt_meta_q <= 1'b0;
            dt_sync_q <= 1'b0;
        end else begin
            ck_meta_q <= ck_i;
            ck_sync_q <= ck_meta_q;
            ck_prev_q <= ck_sync_q;
            dt_meta_q <= dt_i;
            dt_sync_q <= dt_meta_q;
        end
    end

    // leading edge leaves the idle level, trailing edge returns to it
    assign slave_lead = (ck_prev_q == cfg_q.polarity) && (ck_sync_q != cfg_q.polarity);
    assign slave_trail = (ck_prev_q != cfg_q.polarity) && (ck_sync_q == cfg_q.polarity);

    //////////////////////////////////////////////////////////////////////////
    // shift engine
    assign rx_run = cfg_q.port_en && cfg_q.sync && (single_q || cont_q) && !overrun_q;
    assign last_bit = (cfg_q.nine_bit ? ssr_pkg::CHAR_BITS_9 : ssr_pkg::CHAR_BITS_8) - 4'h1;
    assign step_lead = cfg_q.master ? tick : slave_lead;
    assign step_trail = cfg_q.master ? tick : slave_trail;
    assign char_done = (state_q == ssr_pkg::ST_DONE);

    ssr_rate_gen u_rate_gen (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .run_i(rx_run && cfg_q.master && (state_q != ssr_pkg::ST_IDLE)),
        .wide_i(cfg_q.wide),
        .divisor_i(div_q),
        .tick_o(tick)
    );

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !rx_run) begin
            // losing an enable mid character abandons it
            state_q <= ssr_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
        end else begin
            case (state_q)
                ssr_pkg::ST_IDLE: begin
                    state_q <= ssr_pkg::ST_SETUP;
                    bit_cnt_q <= 4'h0;
                end
                ssr_pkg::ST_SETUP: begin
                    if (step_lead) begin
                        state_q <= ssr_pkg::ST_ACTIVE;
                    end
                end
                ssr_pkg::ST_ACTIVE: begin
                    if (step_trail) begin
                        if (bit_cnt_q == last_bit) begin
                            state_q <= ssr_pkg::ST_DONE;
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            state_q <= ssr_pkg::ST_SETUP;
                        end
                    end
                end
                ssr_pkg::ST_DONE: begin
                    // single mode ends here; continuous goes on without pause
                    state_q <= cont_q ? ssr_pkg::ST_SETUP : ssr_pkg::ST_IDLE;
                    bit_cnt_q <= 4'h0;
                end
                default: begin
                    state_q <= ssr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // bits arrive lsb first; the ninth lands in the top position
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_q == ssr_pkg::ST_IDLE) begin
            rsr_q <= 9'h000;
        end else if (state_q == ssr_pkg::ST_ACTIVE && step_trail) begin
            rsr_q[bit_cnt_q] <= dt_sync_q;
        end
    end

    // master clock pin: active level between leading and trailing edges
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ck_o <= 1'b0;
            ck_oe_o <= 1'b0;
        end else begin
            ck_oe_o <= cfg_q.port_en && cfg_q.sync && cfg_q.master;
            if (rx_run && cfg_q.master && state_q == ssr_pkg::ST_SETUP && step_lead) begin
                ck_o <= !cfg_q.polarity;
            end else if (!rx_run || state_q != ssr_pkg::ST_ACTIVE || step_trail) begin
                ck_o <= cfg_q.polarity;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // receive fifo
    assign fifo_full = (count_q == FIFO_FULL);
    assign fifo_empty = (count_q == '0);
    assign push = char_done && !fifo_full;
    assign pop = rd_fire && (paddr_i == ssr_pkg::ADDR_RX_DATA) && !fifo_empty;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            fifo_mem[wr_ptr_q] <= '{ninth: cfg_q.nine_bit && rsr_q[8], low: rsr_q[7:0]};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !cfg_q.port_en) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= PW'((32'(wr_ptr_q) + 1) % FIFO_DEPTH);
            end
            if (pop) begin
                rd_ptr_q <= PW'((32'(rd_ptr_q) + 1) % FIFO_DEPTH);
            end
            if (push && !pop) begin
                count_q <= count_q + CW'(1);
            end else if (pop && !push) begin
                count_q <= count_q - CW'(1);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // overrun: set wins over the pop and continuous-mode clears in the same cycle; reset and port disable win over set
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !cfg_q.port_en) begin
            overrun_q <= 1'b0;
            ovr_cont_q <= 1'b0;
        end else if (char_done && fifo_full) begin
            overrun_q <= 1'b1;
            ovr_cont_q <= cont_q;
        end else if (overrun_q && !ovr_cont_q && pop) begin
            overrun_q <= 1'b0;
        end else if (overrun_q && ovr_cont_q && !cont_q) begin
            overrun_q <= 1'b0;
        end
    end

    // receive interrupt is the fifo's non-empty state gated by the interrupt enable, registered one cycle
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rx_irq_o <= 1'b0;
        end else begin
            rx_irq_o <= !fifo_empty && rx_ie_q;
        end
    end
endmodule : ssr_receiver
